// >>> core/ept_pkg.sv
/*
 * Constants, register map, field positions and clock-select decoding for the
 * eight-bit interval / PWM timer.
 * Assumes an 8-bit register port with 16-bit addresses and one 200 MHz clock.
 */
package ept_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 8;
    localparam int SEL_W  = 3;
    localparam int DIV_W  = 13;

    localparam real CLK_PERIOD_NS = 5.0;

    // register addresses, unit 0 and unit 1
    localparam logic [ADDR_W-1:0] ADDR_CMP0  = 16'hFF17;
    localparam logic [ADDR_W-1:0] ADDR_CMP1  = 16'hFF41;
    localparam logic [ADDR_W-1:0] ADDR_SEL0  = 16'hFF6A;
    localparam logic [ADDR_W-1:0] ADDR_SEL1  = 16'hFF8C;
    localparam logic [ADDR_W-1:0] ADDR_MODE0 = 16'hFF6B;
    localparam logic [ADDR_W-1:0] ADDR_MODE1 = 16'hFF43;
    localparam logic [ADDR_W-1:0] ADDR_CNT0  = 16'hFFE0;
    localparam logic [ADDR_W-1:0] ADDR_CNT1  = 16'hFFE4;
    localparam logic [ADDR_W-1:0] ADDR_STAT0 = 16'hFFE1;
    localparam logic [ADDR_W-1:0] ADDR_STAT1 = 16'hFFE5;
    localparam logic [ADDR_W-1:0] ADDR_MASK0 = 16'hFFE2;
    localparam logic [ADDR_W-1:0] ADDR_MASK1 = 16'hFFE6;

    // mode and status register fields
    localparam int MODE_EN_BIT  = 7;
    localparam int MODE_PWM_BIT = 6;
    localparam int MODE_SET_BIT = 3;
    localparam int MODE_CLR_BIT = 2;
    localparam int MODE_INV_BIT = 1;
    localparam int MODE_OE_BIT  = 0;
    localparam int STAT_MATCH_BIT = 0;

    // reset values, counter top and empty read data
    localparam logic [CNT_W-1:0]  CMP_RST  = 8'h00;
    localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
    localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_TOP  = 8'hFF;
    localparam logic [DATA_W-1:0] READ_NONE = 8'h00;

    typedef enum logic [SEL_W-1:0] {
        SEL_PIN_FALL = 3'h0,
        SEL_PIN_RISE = 3'h1,
        SEL_DIV_1    = 3'h2,
        SEL_DIV_2    = 3'h3,
        SEL_DIV_MID  = 3'h4,
        SEL_DIV_64   = 3'h5,
        SEL_DIV_256  = 3'h6,
        SEL_DIV_MAX  = 3'h7
    } ept_sel_t;

    // low bits of the free-running divider that must all be ones for a tick
    function automatic logic [DIV_W-1:0] ept_div_mask(input logic [SEL_W-1:0] sel,
                                                      input bit unit);
        logic [DIV_W-1:0] m;
        m = 13'h0000;
        case (ept_sel_t'(sel))
            SEL_DIV_2:   m = 13'h0001;
            SEL_DIV_MID: m = unit ? 13'h000F : 13'h0003;
            SEL_DIV_64:  m = 13'h003F;
            SEL_DIV_256: m = 13'h00FF;
            SEL_DIV_MAX: m = unit ? 13'h0FFF : 13'h1FFF;
            default:     m = 13'h0000;
        endcase
        return m;
    endfunction

endpackage

// >>> core/ept_count_clock.sv
/*
 * Count clock generator: synchronises the event pin, detects its edges and
 * divides the system clock, then issues one-cycle count ticks.
 * Assumes the event pin is asynchronous and that the select is stable while run.
 */
`timescale 1ns/1ps
`default_nettype none

module ept_count_clock
    import ept_pkg::*;
#(
    parameter bit UNIT = 1'b0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // control
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] sel,
    // pin and tick
    input  wire logic             event_in_pin,
    output logic                  tick
);

    typedef struct packed {
        logic             meta;
        logic             sync;
        logic             prev;
        logic [DIV_W-1:0] div;
        logic             tick;
    } ept_clk_state_t;

    ept_clk_state_t s_q;
    ept_clk_state_t s_d;

    always_comb begin
        logic             rise;
        logic             fall;
        logic [DIV_W-1:0] mask;
        rise = s_q.sync & ~s_q.prev;
        fall = ~s_q.sync & s_q.prev;
        mask = ept_div_mask(sel, UNIT);
        s_d = s_q;
        s_d.meta = event_in_pin;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
        // divider restarts with each run so the first tick has fixed latency
        s_d.div  = run ? s_q.div + 13'h0001 : 13'h0000;
        s_d.tick = 1'b0;
        if (run) begin
            unique case (ept_sel_t'(sel))
                SEL_PIN_FALL: s_d.tick = fall;
                SEL_PIN_RISE: s_d.tick = rise;
                default:      s_d.tick = (s_q.div & mask) == mask;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

`default_nettype wire

// >>> core/ept_timer.sv
/*
 * Eight-bit interval / PWM timer channel: register port, counter, compare,
 * timer output flip-flop and interrupt status/mask.
 * Assumes a single-cycle strobe register master that never issues read and
 * write together; UNIT picks the address set and divider table.
 */
`timescale 1ns/1ps
`default_nettype none

module ept_timer
    import ept_pkg::*;
#(
    parameter bit UNIT = 1'b0
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    // pins
    input  wire logic              event_in_pin,
    output logic                   timer_out_pin,
    // interrupts
    output logic                   match_irq,
    output logic                   irq
);

    localparam logic [ADDR_W-1:0] A_CMP  = UNIT ? ADDR_CMP1  : ADDR_CMP0;
    localparam logic [ADDR_W-1:0] A_SEL  = UNIT ? ADDR_SEL1  : ADDR_SEL0;
    localparam logic [ADDR_W-1:0] A_MODE = UNIT ? ADDR_MODE1 : ADDR_MODE0;
    localparam logic [ADDR_W-1:0] A_CNT  = UNIT ? ADDR_CNT1  : ADDR_CNT0;
    localparam logic [ADDR_W-1:0] A_STAT = UNIT ? ADDR_STAT1 : ADDR_STAT0;
    localparam logic [ADDR_W-1:0] A_MASK = UNIT ? ADDR_MASK1 : ADDR_MASK0;

    typedef struct packed {
        logic [CNT_W-1:0]  cmp;
        logic [SEL_W-1:0]  sel;
        logic              en;
        logic              pwm;
        logic              inv;
        logic              oe;
        logic [CNT_W-1:0]  cnt;
        logic              tff;
        logic              pwm_act;
        logic              stat;
        logic              mask;
        logic              match_pulse;
        logic              out;
        logic              irq;
        logic [DATA_W-1:0] rd_data;
    } ept_state_t;

    ept_state_t s_q;
    ept_state_t s_d;
    logic       tick;

    ept_count_clock #(
        .UNIT (UNIT)
    ) u_count_clock (
        .clk          (clk),
        .reset        (reset),
        .run          (s_q.en),
        .sel          (s_q.sel),
        .event_in_pin (event_in_pin),
        .tick         (tick)
    );

    always_comb begin
        logic             match;
        logic             event_hit;
        logic [CNT_W-1:0] next_cnt;
        match     = s_q.cnt == s_q.cmp;
        next_cnt  = s_q.cnt + 8'h01;
        event_hit = 1'b0;
        s_d = s_q;
        s_d.match_pulse = 1'b0;

        // counting; writes below may override for the same edge
        if (!s_q.en) begin
            s_d.cnt     = CNT_RST;
            s_d.pwm_act = 1'b0;
        end else if (tick) begin
            if (!s_q.pwm) begin
                if (match) begin
                    s_d.cnt   = CNT_RST;
                    event_hit = 1'b1;
                    if (s_q.inv) begin
                        s_d.tff = ~s_q.tff;
                    end
                end else begin
                    s_d.cnt = next_cnt;
                end
            end else begin
                s_d.cnt = next_cnt;
                if (s_q.cnt == CNT_TOP) begin
                    s_d.pwm_act = 1'b1;
                end
                // match after wrap wins, so compare 00H gives a flat inactive output
                if (next_cnt == s_q.cmp) begin
                    s_d.pwm_act = 1'b0;
                end
            end
        end

        // register writes; the counter address takes no write
        if (wr_en) begin
            unique case (addr)
                A_CMP: s_d.cmp = wr_data;
                A_SEL: s_d.sel = wr_data[SEL_W-1:0];
                A_MODE: begin
                    s_d.en  = wr_data[MODE_EN_BIT];
                    s_d.pwm = wr_data[MODE_PWM_BIT];
                    s_d.inv = wr_data[MODE_INV_BIT];
                    s_d.oe  = wr_data[MODE_OE_BIT];
                    if (!wr_data[MODE_PWM_BIT]) begin
                        if (wr_data[MODE_SET_BIT] && !wr_data[MODE_CLR_BIT]) begin
                            s_d.tff = 1'b1;
                        end else if (!wr_data[MODE_SET_BIT] && wr_data[MODE_CLR_BIT]) begin
                            s_d.tff = 1'b0;
                        end
                    end
                    if (wr_data[MODE_EN_BIT] && !s_q.en && wr_data[MODE_PWM_BIT]) begin
                        s_d.pwm_act = s_q.cmp != CMP_RST;
                    end
                end
                A_STAT: s_d.stat = s_q.stat & ~wr_data[STAT_MATCH_BIT];
                A_MASK: s_d.mask = wr_data[STAT_MATCH_BIT];
                default: ;
            endcase
        end

        // a match in the clearing cycle still sets the flag
        if (event_hit) begin
            s_d.match_pulse = 1'b1;
            s_d.stat        = 1'b1;
        end

        s_d.irq = s_d.stat & s_d.mask;
        if (!s_d.oe) begin
            s_d.out = 1'b0;
        end else if (s_d.pwm) begin
            s_d.out = s_d.pwm_act ^ s_d.inv;
        end else begin
            s_d.out = s_d.tff;
        end

        // read data appears in the cycle after the strobe
        s_d.rd_data = READ_NONE;
        if (rd_en) begin
            unique case (addr)
                A_CMP:   s_d.rd_data = s_q.cmp;
                A_SEL:   s_d.rd_data = {5'h00, s_q.sel};
                A_MODE:  s_d.rd_data = {s_q.en, s_q.pwm, 4'h0, s_q.inv, s_q.oe};
                A_CNT:   s_d.rd_data = s_q.cnt;
                A_STAT:  s_d.rd_data = {7'h00, s_q.stat};
                A_MASK:  s_d.rd_data = {7'h00, s_q.mask};
                default: s_d.rd_data = READ_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q      <= '0;
            s_q.cmp  <= CMP_RST;
            s_q.sel  <= SEL_RST;
            s_q.cnt  <= CNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data       = s_q.rd_data;
    assign timer_out_pin = s_q.out;
    assign match_irq     = s_q.match_pulse;
    assign irq           = s_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_step_plain;
        s_q.en && tick && !(s_q.pwm == 1'b0 && s_q.cnt == s_q.cmp) && !wr_en;
    endsequence

    sequence s_clear_match;
        s_q.en && tick && !s_q.pwm && s_q.cnt == s_q.cmp && !wr_en;
    endsequence

    sequence s_pwm_match;
        s_q.en && s_q.pwm && tick && (s_q.cnt + 8'h01) == s_q.cmp && !wr_en;
    endsequence

    sequence s_div1_held;
        (s_q.en && s_q.sel == SEL_DIV_1 && !wr_en) ##1 (s_q.en && s_q.sel == SEL_DIV_1);
    endsequence

    property p_cnt_step;
        s_step_plain |=> s_q.cnt == $past(s_q.cnt) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

    property p_cnt_no_write;
        (wr_en && addr == A_CNT && !tick) |=> s_q.cnt == $past(s_q.cnt) || s_q.cnt == CNT_RST;
    endproperty
    a_cnt_no_write: assert property (p_cnt_no_write) else $error("counter took a write");

    property p_disable_clears;
        (!s_q.en && !wr_en) |=> s_q.cnt == CNT_RST && !s_q.pwm_act;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disable did not clear");

    property p_clear_start;
        s_clear_match |=> (s_q.cnt == CNT_RST && match_irq && s_q.stat)
            ##1 (match_irq == ($past(tick) && $past(s_q.cmp) == CNT_RST));
    endproperty
    a_clear_start: assert property (p_clear_start) else $error("match did not clear and flag");

    property p_reset_values;
        disable iff (1'b0) reset |=> s_q.cmp == CMP_RST && s_q.sel == SEL_RST && s_q.cnt == CNT_RST;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_pwm_match;
        s_pwm_match |=> !match_irq && timer_out_pin == (s_q.oe & s_q.inv);
    endproperty
    a_pwm_match: assert property (p_pwm_match) else $error("pwm match output wrong");

    property p_cmp_write;
        (wr_en && addr == A_CMP) |=> s_q.cmp == $past(wr_data);
    endproperty
    a_cmp_write: assert property (p_cmp_write) else $error("compare write lost");

    property p_div1_tick;
        s_div1_held |-> tick;
    endproperty
    a_div1_tick: assert property (p_div1_tick) else $error("undivided clock missed a tick");

    property p_pwm_wrap;
        (s_q.en && s_q.pwm && tick && s_q.cnt == CNT_TOP && s_q.cmp != CMP_RST && !wr_en)
            |=> s_q.pwm_act;
    endproperty
    a_pwm_wrap: assert property (p_pwm_wrap) else $error("wrap did not reactivate output");

    sequence s_pwm_start;
        wr_en && addr == A_MODE && wr_data[MODE_EN_BIT] && wr_data[MODE_PWM_BIT]
            && !s_q.en && s_q.cmp != CMP_RST;
    endsequence

    property p_pwm_start;
        s_pwm_start |=> s_q.pwm_act;
    endproperty
    a_pwm_start: assert property (p_pwm_start) else $error("pwm start not active");

    property p_cnt_read;
        (rd_en && addr == A_CNT) |=> rd_data == $past(s_q.cnt);
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counter read wrong");

    property p_stat_sticky;
        (s_q.stat && !wr_en) |=> s_q.stat;
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

    property p_irq_set;
        (s_q.stat && s_q.mask && !wr_en) |=> irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("unmasked status gave no irq");

    property p_irq_masked;
        (!s_q.mask && !wr_en) |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked status raised irq");

    property p_pwm_no_irq;
        s_q.pwm |=> !match_irq;
    endproperty
    a_pwm_no_irq: assert property (p_pwm_no_irq) else $error("pwm mode raised match pulse");

    property p_sel_write;
        (wr_en && addr == A_SEL) |=> s_q.sel == $past(wr_data[SEL_W-1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("clock select write lost");

    property p_en_write;
        (wr_en && addr == A_MODE) |=> s_q.en == $past(wr_data[MODE_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_stop_no_tick;
        !s_q.en |=> !tick;
    endproperty
    a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped");

    property p_mode_write;
        (wr_en && addr == A_MODE) |=> s_q.pwm == $past(wr_data[MODE_PWM_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_disable_out;
        (!s_q.en && s_q.pwm && !wr_en) |=> timer_out_pin == (s_q.oe & s_q.inv);
    endproperty
    a_disable_out: assert property (p_disable_out) else $error("stopped pwm output active");

endmodule

`default_nettype wire

// >>> test/ept_pin_model.sv
/*
 * Far-side model: drives the event input pin and counts what the timer
 * puts out (cycles of high output, match pulses).
 * Assumes the bench clock; pulse is called from the bench thread.
 */
`timescale 1ns/1ps
`default_nettype none

module ept_pin_model (
    // clock
    input  wire logic clk,
    // pins seen
    input  wire logic timer_out_pin,
    input  wire logic match_irq,
    // pin driven
    output logic      event_in_pin
);
    int hi_cnt  = 0;
    int irq_cnt = 0;

    initial event_in_pin = 1'b0;

    always @(posedge clk) begin
        if (timer_out_pin === 1'b1) hi_cnt <= hi_cnt + 1;
        if (match_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // levels held six cycles so the two-flop synchroniser sees each one
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            event_in_pin <= 1'b1;
            repeat (6) @(posedge clk);
            event_in_pin <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// >>> test/test_ept_timer.sv
/*
 * Self-checking bench for the timer channel, unit 0: register reads and
 * writes, clear-and-start and PWM timing, dividers, pin edges, interrupt.
 * Assumes the pin model beside it and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ept_timer;
    import ept_pkg::*;

    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              event_in_pin;
    logic              timer_out_pin;
    logic              match_irq;
    logic              irq;
    int                n_mismatch = 0;
    int                checked = 0;
    int                ni;
    int                nh;
    int                divs[6] = '{1, 2, 4, 64, 256, 8192};

    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

    ept_timer #(.UNIT(1'b0)) dut (
        .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .event_in_pin(event_in_pin), .timer_out_pin(timer_out_pin),
        .match_irq(match_irq), .irq(irq)
    );

    ept_pin_model pins (
        .clk(clk), .timer_out_pin(timer_out_pin), .match_irq(match_irq),
        .event_in_pin(event_in_pin)
    );

    task automatic report_and_stop;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        checked++;
        if (got != exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // an idle cycle follows each strobe so no signal is assigned twice at one edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk8(rd_data, exp);
        @(posedge clk);
    endtask

    // stop first: select, compare and mode change only while stopped
    task automatic run(input logic [2:0] s, input logic [7:0] c, input logic [7:0] m);
        wr(ADDR_MODE0, 8'h00);
        wr(ADDR_SEL0, {5'h00, s});
        wr(ADDR_CMP0, c);
        wr(ADDR_MODE0, m);
    endtask

    // counts over exactly w cycles, sampled away from the rising edge
    task automatic window(input int w, output int irqs, output int his);
        int a;
        int b;
        @(negedge clk);
        a = pins.irq_cnt;
        b = pins.hi_cnt;
        repeat (w) @(negedge clk);
        irqs = pins.irq_cnt - a;
        his = pins.hi_cnt - b;
        @(posedge clk);
    endtask

    task automatic chk_out(input logic got_irq, input logic exp_irq);
        chk8({7'h00, got_irq}, {7'h00, exp_irq});
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_CMP0, 8'h00);
        rd_chk(ADDR_SEL0, 8'h00);
        rd_chk(ADDR_CNT0, 8'h00);
        rd_chk(16'h0000, READ_NONE);
        $display("test reset_values done");

        run(3'h2, 8'h02, 8'h80);
        repeat (10) @(posedge clk);
        window(30, ni, nh);
        chk_n(ni, 10);
        run(3'h2, 8'hFF, 8'h80);
        repeat (300) @(posedge clk);
        window(512, ni, nh);
        chk_n(ni, 2);
        wr(ADDR_MODE0, 8'h00);
        rd_chk(ADDR_CNT0, 8'h00);
        rd_chk(ADDR_STAT0, 8'h01);
        @(negedge clk);
        chk_out(irq, 1'b0);
        @(posedge clk);
        wr(ADDR_MASK0, 8'h01);
        @(negedge clk);
        chk_out(irq, 1'b1);
        @(posedge clk);
        wr(ADDR_STAT0, 8'h01);
        @(negedge clk);
        chk_out(irq, 1'b0);
        @(posedge clk);
        rd_chk(ADDR_STAT0, 8'h00);
        // output flip-flop toggles on each match: three cycles high, three low
        run(3'h2, 8'h02, 8'h87);
        repeat (10) @(posedge clk);
        window(30, ni, nh);
        chk_n(nh, 15);
        wr(ADDR_MODE0, 8'h09);
        @(negedge clk);
        chk_out(timer_out_pin, 1'b1);
        @(posedge clk);
        rd_chk(ADDR_MODE0, 8'h01);
        wr(ADDR_MODE0, 8'h05);
        @(negedge clk);
        chk_out(timer_out_pin, 1'b0);
        @(posedge clk);
        $display("test clear_and_start done");

        for (int s = 2; s < 8; s++) begin
            run(s[2:0], 8'h00, 8'h80);
            rd_chk(ADDR_SEL0, {5'h00, s[2:0]});
            repeat (divs[s-2] + 8) @(posedge clk);
            window(2 * divs[s-2], ni, nh);
            chk_n(ni, 2);
        end
        $display("test dividers done");

        run(3'h0, 8'hFF, 8'h80);
        pins.pulse(5);
        repeat (8) @(posedge clk);
        rd_chk(ADDR_CNT0, 8'h05);
        wr(ADDR_CNT0, 8'hFF);
        rd_chk(ADDR_CNT0, 8'h05);
        run(3'h1, 8'hFF, 8'h80);
        pins.pulse(3);
        repeat (8) @(posedge clk);
        rd_chk(ADDR_CNT0, 8'h03);
        $display("test pin_edges done");

        run(3'h2, 8'h40, 8'hC1);
        repeat (300) @(posedge clk);
        window(512, ni, nh);
        chk_n(nh, 128);
        chk_n(ni, 0);
        wr(ADDR_MODE0, 8'h41);
        repeat (2) @(negedge clk);
        chk_out(timer_out_pin, 1'b0);
        @(posedge clk);
        rd_chk(ADDR_CNT0, 8'h00);
        $display("test pwm done");
        report_and_stop();
    end
endmodule

`default_nettype wire
